/* File: rtl/flpd_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Serial command interpreter for block lock, power-down and reset handling of a flash.

module flpd_ctrl
  import flpd_pkg::*;
(
  // Clock and synchronous reset (power-on).
  input wire logic clk,
  input wire logic resetn,
  // SPI pins, asynchronous to clk.
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  // Reset sources and configuration.
  input wire logic jedec_reset,
  input wire logic reset_pin_n,
  input wire logic reset_pin_enable,
  input wire logic power_down_select_bit,
  // Status.
  output logic busy,
  output logic deep_power_down_state,
  output logic deepest_power_down_state,
  output logic waking,
  output logic op_refused,
  output logic op_aborted,
  output logic device_reset_pulse,
  output logic sram_valid
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BUSY = 3'b001,
    ST_DEEP = 3'b010,
    ST_DEEPEST = 3'b011,
    ST_WAKE = 3'b100,
    ST_RESET = 3'b101
  } flpd_state_e;

  flpd_state_e state;
  flpd_state_e next_state;

  // Pin synchronisers: second stage is the only reader of the first.
  logic [1:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] si_s;
  logic [1:0] rp_s;
  logic [1:0] jr_s;
  logic sck_d;
  logic jr_d;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sck_s <= 2'b00;
      cs_s <= 2'b11;
      si_s <= 2'b00;
      rp_s <= 2'b11;
      jr_s <= 2'b00;
      sck_d <= 1'b0;
      jr_d <= 1'b0;
    end else begin
      sck_s <= {sck_s[0], spi_sck};
      cs_s <= {cs_s[0], spi_cs_n};
      si_s <= {si_s[0], spi_si};
      rp_s <= {rp_s[0], reset_pin_n};
      jr_s <= {jr_s[0], jedec_reset};
      sck_d <= sck_s[1];
      jr_d <= jr_s[1];
    end
  end

  wire cs_active = !cs_s[1];
  wire sck_rise = cs_active && sck_s[1] && !sck_d;
  wire sck_fall = cs_active && !sck_s[1] && sck_d;
  // The reset pin acts only while its function is enabled; a low level holds the reset sequence.
  wire pin_reset = reset_pin_enable && !rp_s[1];
  wire jedec_hit = jr_s[1] && !jr_d;
  // External resets wake from either power-down and abort any operation.
  wire hard_reset = pin_reset || jedec_hit;

  // Command shifter.
  logic [5:0] bit_cnt;
  logic [7:0] opcode;
  logic [ADDR_W-1:0] addr;
  logic reset_armed;
  logic [7:0] lock_shift;
  logic lock_out_active;
  logic [3:0] out_cnt;

  wire [7:0] next_opcode = {opcode[6:0], si_s[1]};
  wire [ADDR_W-1:0] next_addr = {addr[ADDR_W-2:0], si_s[1]};
  // Bit counts are taken before the increment, so bit 7 is the last opcode bit and bit 31 the last address bit.
  wire op_done = sck_rise && bit_cnt == 6'd7;
  wire addr_done = sck_rise && bit_cnt == 6'd31;
  wire is_read_lock = opcode == OP_READ_LOCK_A || opcode == OP_READ_LOCK_B;
  wire is_program = next_opcode == OP_PROG_PAGE || next_opcode == OP_PROG_SEQ_A
    || next_opcode == OP_PROG_SEQ_B || next_opcode == OP_PROG_DUAL
    || next_opcode == OP_PROG_QUAD || next_opcode == OP_PROG_OTP;
  wire is_erase = next_opcode == OP_ERASE_4K || next_opcode == OP_ERASE_32K
    || next_opcode == OP_ERASE_64K || next_opcode == OP_ERASE_CHIP_A
    || next_opcode == OP_ERASE_CHIP_B;
  wire is_chip_erase = next_opcode == OP_ERASE_CHIP_A || next_opcode == OP_ERASE_CHIP_B;
  wire powered_down = state == ST_DEEP || state == ST_DEEPEST;
  wire op_in_idle = op_done && state == ST_IDLE;
  // The reset pair needs 66h as the opcode of the previous frame; any other frame disarms it.
  wire sw_reset = op_done && reset_armed && next_opcode == OP_RESET_DEVICE;
  // Program and erase other than chip erase carry an address; they start at address completion.
  wire pe_cmd = (is_program || is_erase) && !is_chip_erase;

  // Address to lock index: 4 kB granularity in the outer 64 kB blocks.
  // Only bits 21:16 select a 64 kB block; higher address bits lie beyond the array and are ignored.
  wire [5:0] blk64 = addr[21:16];
  wire [3:0] sub4k = addr[15:12];
  logic [LOCK_IDX_W-1:0] lock_idx;
  assign lock_idx = blk64 == 6'd0 ? {3'b000, sub4k}
    : blk64 == 6'(BLK64_LAST) ? LOCK_IDX_W'(TOP_BASE) + {3'b000, sub4k}
    : LOCK_IDX_W'(15) + {1'b0, blk64};
  wire [LOCK_IDX_W-1:0] next_idx = {3'b000, next_addr[15:12]} == 7'd0 && next_addr[21:16] == 6'd0 ? 7'd0
    : next_addr[21:16] == 6'd0 ? {3'b000, next_addr[15:12]}
    : next_addr[21:16] == 6'(BLK64_LAST) ? LOCK_IDX_W'(TOP_BASE) + {3'b000, next_addr[15:12]}
    : LOCK_IDX_W'(15) + {1'b0, next_addr[21:16]};

  // Lock store; internal resets re-set all bits.
  logic soft_reset;
  logic lock_bit;
  wire glob_lock = op_in_idle && next_opcode == OP_GLOBAL_LOCK;
  wire glob_unlock = op_in_idle && next_opcode == OP_GLOBAL_UNLOCK;
  // The read index follows the shifting address on the last address bit so the lock bit is ready early.
  flpd_lock_mem u_lock (
    .clk(clk),
    .resetn(resetn),
    .soft_reset(soft_reset),
    .set_all(glob_lock),
    .clear_all(glob_unlock),
    .rd_idx(addr_done ? next_idx : lock_idx),
    .rd_bit(lock_bit)
  );
  logic lock_valid;
  logic pe_pending;
  logic chip_pending;
  logic opcode_is_pe;

  // Timer shared by busy, wake and internal reset.
  logic [CNT_W-1:0] timer;
  wire timer_done = timer == '0;

  // Outside resets are applied last so that they override any command decoded in the same cycle.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (op_in_idle && next_opcode == OP_POWER_DOWN) begin
          next_state = power_down_select_bit ? ST_DEEP : ST_DEEPEST;
        end else if (op_in_idle && next_opcode == OP_DEEPEST_DOWN) begin
          next_state = ST_DEEPEST;
        end else if (lock_valid && pe_pending && !lock_bit) begin
          next_state = ST_BUSY;
        end else if (chip_pending) begin
          next_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        // F0h halts the operation without any internal reset.
        if (op_done && next_opcode == OP_TERMINATE) begin
          next_state = ST_IDLE;
        end else if (timer_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_DEEP: begin
        // Chip select release and F0h fall through here and change nothing.
        if (op_done && next_opcode == OP_RESUME) begin
          next_state = ST_WAKE;
        end
      end
      ST_DEEPEST: begin
        if (op_done && next_opcode == OP_RESUME) begin
          next_state = ST_RESET;
        end
      end
      ST_WAKE: begin
        if (timer_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_RESET: begin
        if (timer_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // The reset pair is honoured in deep but not deepest power-down.
    if (sw_reset && state != ST_DEEPEST) begin
      next_state = ST_RESET;
    end
    if (hard_reset) begin
      next_state = ST_RESET;
    end
  end

  // The timer loads only on a change of state, so a reset held for several cycles runs one sequence.
  wire enter_wait = next_state != state;
  logic [CNT_W-1:0] next_timer;
  always_comb begin
    next_timer = timer_done ? timer : timer - CNT_W'(1);
    if (enter_wait) begin
      unique case (next_state)
        ST_BUSY: next_timer = CNT_W'(OP_BUSY_CYC);
        ST_WAKE: next_timer = CNT_W'(DEEP_WAKE_CYC);
        ST_RESET: next_timer = state == ST_DEEPEST ? CNT_W'(DEEPEST_WAKE_CYC) : CNT_W'(RESET_SEQ_CYC);
        default: next_timer = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      timer <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // Command shift register; powered-down states ignore all but exit opcodes.
  always_ff @(posedge clk) begin
    if (!resetn || !cs_active) begin
      bit_cnt <= '0;
    end else if (sck_rise && bit_cnt != 6'd63) begin
      bit_cnt <= bit_cnt + 6'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      opcode <= '0;
      addr <= '0;
      reset_armed <= 1'b0;
      pe_pending <= 1'b0;
      chip_pending <= 1'b0;
      lock_valid <= 1'b0;
    end else begin
      lock_valid <= addr_done;
      if (sck_rise && bit_cnt < 6'd8) begin
        opcode <= next_opcode;
      end
      if (sck_rise && bit_cnt >= 6'd8 && bit_cnt < 6'd32) begin
        addr <= next_addr;
      end
      if (op_done) begin
        reset_armed <= next_opcode == OP_RESET_ENABLE && state != ST_DEEPEST;
      end
      pe_pending <= addr_done && state == ST_IDLE && opcode_is_pe;
      chip_pending <= op_in_idle && is_chip_erase;
    end
  end
  // The opcode class is latched at the eighth bit so the address stage can start the operation.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      opcode_is_pe <= 1'b0;
    end else if (op_done) begin
      opcode_is_pe <= pe_cmd;
    end
  end

  // Lock readback: the field is loaded before the falling edge that ends the last address bit.
  // That falling edge only opens the output window, so the MSB still stands at the next rising
  // edge; the count of nine covers it and the eight bit times that follow.
  always_ff @(posedge clk) begin
    if (!resetn || !cs_active) begin
      lock_out_active <= 1'b0;
      out_cnt <= '0;
      lock_shift <= '0;
    end else if (lock_valid && is_read_lock && state == ST_IDLE) begin
      lock_shift <= {7'h00, lock_bit};
      lock_out_active <= 1'b1;
      out_cnt <= 4'd9;
    end else if (lock_out_active && sck_fall) begin
      if (out_cnt == 4'd1) begin
        lock_out_active <= 1'b0;
      end
      out_cnt <= out_cnt - 4'd1;
      if (out_cnt != 4'd9) begin
        lock_shift <= {lock_shift[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      spi_so <= 1'b0;
      spi_so_oe <= 1'b0;
      busy <= 1'b0;
      deep_power_down_state <= 1'b0;
      deepest_power_down_state <= 1'b0;
      waking <= 1'b0;
      op_refused <= 1'b0;
      op_aborted <= 1'b0;
      device_reset_pulse <= 1'b0;
      soft_reset <= 1'b0;
      sram_valid <= 1'b1;
    end else begin
      // Status outputs other than op_refused follow next_state so they change in the same cycle as the state register.
      spi_so <= lock_shift[7];
      spi_so_oe <= lock_out_active && !powered_down;
      busy <= next_state == ST_BUSY;
      deep_power_down_state <= next_state == ST_DEEP;
      deepest_power_down_state <= next_state == ST_DEEPEST;
      waking <= next_state == ST_WAKE || next_state == ST_RESET;
      op_refused <= lock_valid && pe_pending && lock_bit;
      op_aborted <= state == ST_BUSY && next_state != ST_BUSY && !timer_done;
      device_reset_pulse <= next_state == ST_RESET && state != ST_RESET;
      soft_reset <= next_state == ST_RESET && state != ST_RESET;
      // SRAM contents are lost only on the way out of deepest power-down.
      if (state == ST_DEEPEST && next_state == ST_RESET) begin
        sram_valid <= 1'b0;
      end else if (state == ST_RESET && next_state == ST_IDLE) begin
        sram_valid <= 1'b1;
      end
    end
  end
endmodule : flpd_ctrl
`default_nettype wire

/* File: rtl/flpd_pkg.sv */
// Package with opcodes, lock geometry and timing constants for the lock and power-down controller.
package flpd_pkg;
  localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_READ_LOCK_A = 8'h3C;
  localparam logic [7:0] OP_READ_LOCK_B = 8'h3D;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_DEEPEST_DOWN = 8'h79;
  localparam logic [7:0] OP_RESUME = 8'hAB;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET_DEVICE = 8'h99;
  localparam logic [7:0] OP_TERMINATE = 8'hF0;
  localparam logic [7:0] OP_PROG_PAGE = 8'h02;
  localparam logic [7:0] OP_PROG_SEQ_A = 8'hAF;
  localparam logic [7:0] OP_PROG_SEQ_B = 8'hAD;
  localparam logic [7:0] OP_PROG_DUAL = 8'hA2;
  localparam logic [7:0] OP_PROG_QUAD = 8'h32;
  localparam logic [7:0] OP_PROG_OTP = 8'h9B;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_ERASE_CHIP_A = 8'h60;
  localparam logic [7:0] OP_ERASE_CHIP_B = 8'hC7;
  // Lock map: 16 bottom 4 kB bits, 62 middle 64 kB bits, 16 top 4 kB bits.
  localparam int LOCK_BITS = 94;
  localparam int LOCK_IDX_W = 7;
  localparam int ADDR_W = 24;
  localparam int BLK64_LAST = 63;
  localparam int TOP_BASE = 78;
  localparam logic [LOCK_BITS-1:0] LOCK_RESET = {LOCK_BITS{1'b1}};
  localparam int CLK_MHZ = 100;
  // Exit recovery and operation busy times in microseconds; plain defaults.
  localparam int DEEP_WAKE_US = 3;
  localparam int DEEPEST_WAKE_US = 100;
  localparam int RESET_SEQ_US = 30;
  localparam int OP_BUSY_US = 50;
  localparam int DEEP_WAKE_CYC = DEEP_WAKE_US * CLK_MHZ;
  localparam int DEEPEST_WAKE_CYC = DEEPEST_WAKE_US * CLK_MHZ;
  localparam int RESET_SEQ_CYC = RESET_SEQ_US * CLK_MHZ;
  localparam int OP_BUSY_CYC = OP_BUSY_US * CLK_MHZ;
  localparam int CNT_W = 16;
endpackage : flpd_pkg

/* File: rtl/flpd_lock_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// Lock bit store with global set and clear and a registered read port.
module flpd_lock_mem
  import flpd_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Internal reset on entry to the reset sequence: resume from deepest power-down, reset pair, reset pin or JEDEC reset.
  input wire logic soft_reset,
  // Global commands.
  input wire logic set_all,
  input wire logic clear_all,
  // Read port.
  input wire logic [LOCK_IDX_W-1:0] rd_idx,
  output logic rd_bit
);
  logic [LOCK_BITS-1:0] lock_bits;

  always_ff @(posedge clk) begin
    if (!resetn || soft_reset || set_all) begin
      lock_bits <= LOCK_RESET;
    end else if (clear_all) begin
      lock_bits <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_bit <= 1'b1;
    end else begin
      rd_bit <= lock_bits[rd_idx];
    end
  end
endmodule : flpd_lock_mem
`default_nettype wire

/* File: tb/flpd_ctrl_props.sv */
// Checker with the port-level properties of the lock and power-down controller.
`timescale 1ns/1ps
`default_nettype none
module flpd_ctrl_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Observed ports.
  input wire logic power_down_select_bit,
  input wire logic spi_so_oe,
  input wire logic busy,
  input wire logic deep_power_down_state,
  input wire logic deepest_power_down_state,
  input wire logic waking,
  input wire logic op_refused,
  input wire logic op_aborted,
  input wire logic device_reset_pulse,
  input wire logic sram_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Any way out of power-down must start a recovery or reset sequence.
  sequence s_recover;
    ##[0:2] waking;
  endsequence
  chk_pd_exclusive: assert property (!(deep_power_down_state && deepest_power_down_state))
    else $error("both power-down states set");
  chk_pd_quiet: assert property ((deep_power_down_state || deepest_power_down_state) |-> !spi_so_oe)
    else $error("output driven in power-down");
  chk_deep_select: assert property ($rose(deep_power_down_state) |-> power_down_select_bit)
    else $error("deep state without select bit");
  chk_deep_exit: assert property ($fell(deep_power_down_state) |-> s_recover)
    else $error("deep exit without recovery");
  chk_deepest_exit: assert property ($fell(deepest_power_down_state) |-> s_recover)
    else $error("deepest exit without recovery");
  chk_sram_lost: assert property ($fell(sram_valid) |-> ##[0:2] (waking && !deepest_power_down_state))
    else $error("sram lost outside reset sequence");
  chk_sram_back: assert property ($rose(sram_valid) |-> !deepest_power_down_state)
    else $error("sram valid while deepest");
  chk_refuse_idle: assert property (op_refused |=> !busy [*2])
    else $error("refused operation started");
  chk_abort_stop: assert property (op_aborted |-> ##[0:1] !busy)
    else $error("aborted operation still busy");
  chk_reset_abort: assert property (device_reset_pulse |-> ##[0:2] (!busy && waking))
    else $error("reset left operation running");
endmodule : flpd_ctrl_props
bind flpd_ctrl flpd_ctrl_props u_props (.clk(clk), .resetn(resetn), .power_down_select_bit(power_down_select_bit),
  .spi_so_oe(spi_so_oe), .busy(busy), .deep_power_down_state(deep_power_down_state),
  .deepest_power_down_state(deepest_power_down_state), .waking(waking), .op_refused(op_refused),
  .op_aborted(op_aborted), .device_reset_pulse(device_reset_pulse), .sram_valid(sram_valid));
`default_nettype wire

/* File: tb/flpd_host_model.sv */
// Host SPI master model that sends flash command frames in mode 0.
`timescale 1ns/1ps
`default_nettype none
module flpd_host_model (
  // SPI pins.
  output var logic spi_sck,
  output var logic spi_cs_n,
  output var logic spi_si,
  input wire logic spi_so,
  input wire logic spi_so_oe
);
  // The clock rests low between frames and the data line flips once released.
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end
  task automatic frame(input logic [7:0] op, input int na, input logic [23:0] adr, input int nr,
    output logic [7:0] rd, output logic oe);
    logic [31:0] w;
    w = {op, adr};
    rd = 8'h00;
    oe = 1'b0;
    spi_cs_n = 1'b0;
    #40;
    for (int i = 0; i < 8 + na + nr; i++) begin
      spi_si = (i < 8 + na) ? w[31-i] : ~spi_si;
      #62.5 spi_sck = 1'b1;
      if (i >= 8 + na) begin
        rd = {rd[6:0], spi_so};
        oe = oe | spi_so_oe;
      end
      #62.5 spi_sck = 1'b0;
    end
    #40 spi_cs_n = 1'b1;
    spi_si = ~spi_si;
    #300;
  endtask : frame
endmodule : flpd_host_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the lock and power-down controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flpd_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic jedec_reset = 1'b0;
  logic reset_pin_n = 1'b1;
  logic pin_en = 1'b0;
  logic sel = 1'b0;
  logic so_alt = 1'b0;
  logic f_ref, f_ab, f_rst;
  wire sck, cs_n, si, so, so_oe, so_line, busy, deep, deepest, waking, refused, aborted, rst_pulse, sram_valid;
  int mismatches = 0;
  int total_checks = 0;
  logic [7:0] ops [11];
  always #5 clk = ~clk;
  // An undriven output line is modelled as changing every cycle.
  always @(posedge clk) so_alt <= ~so_alt;
  assign so_line = so_oe ? so : so_alt;
  always @(posedge clk) begin
    f_ref <= f_ref | (refused === 1'b1);
    f_ab <= f_ab | (aborted === 1'b1);
    f_rst <= f_rst | (rst_pulse === 1'b1);
  end
  flpd_ctrl dut (.clk(clk), .resetn(resetn), .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si), .spi_so(so),
    .spi_so_oe(so_oe), .jedec_reset(jedec_reset), .reset_pin_n(reset_pin_n), .reset_pin_enable(pin_en),
    .power_down_select_bit(sel), .busy(busy), .deep_power_down_state(deep), .deepest_power_down_state(deepest),
    .waking(waking), .op_refused(refused), .op_aborted(aborted), .device_reset_pulse(rst_pulse),
    .sram_valid(sram_valid));
  flpd_host_model host (.spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si), .spi_so(so_line), .spi_so_oe(so_oe));
  task cmp_bit(input string what, input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : cmp_bit
  task cmp_byte(input string what, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h", $time, what, got);
    end
  endtask : cmp_byte
  task clr;
    @(negedge clk);
    f_ref = 1'b0;
    f_ab = 1'b0;
    f_rst = 1'b0;
  endtask : clr
  task send(input logic [7:0] op, input int na, input logic [23:0] adr);
    logic [7:0] rd;
    logic oe;
    clr;
    host.frame(op, na, adr, 0, rd, oe);
    repeat (8) @(negedge clk);
  endtask : send
  task rdlock(input logic [7:0] op, input logic [23:0] adr, input logic [7:0] exp, input logic exp_oe);
    logic [7:0] rd;
    logic oe;
    clr;
    host.frame(op, 24, adr, 8, rd, oe);
    cmp_bit("lock output enable", oe, exp_oe);
    if (exp_oe) cmp_byte("lock field", rd, exp);
  endtask : rdlock
  task wait_wake;
    for (int n = 0; n < 25000 && waking !== 1'b0; n++) @(negedge clk);
    cmp_bit("wake finished", waking, 1'b0);
  endtask : wait_wake
  task jedec;
    clr;
    jedec_reset = 1'b1;
    repeat (10) @(negedge clk);
    jedec_reset = 1'b0;
    repeat (8) @(negedge clk);
  endtask : jedec
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial begin
    #1_000_000;
    mismatches++;
    end_sim;
  end
  initial begin
    ops = '{OP_PROG_PAGE, OP_PROG_SEQ_A, OP_PROG_SEQ_B, OP_PROG_DUAL, OP_PROG_QUAD, OP_PROG_OTP,
      OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_ERASE_CHIP_A, OP_ERASE_CHIP_B};
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (5) @(negedge clk);
    rdlock(OP_READ_LOCK_A, 24'h00_0000, 8'h01, 1'b1);
    rdlock(OP_READ_LOCK_B, 24'h3F_F000, 8'h01, 1'b1);
    send(OP_ERASE_4K, 24, 24'h00_0000);
    cmp_bit("refused", f_ref, 1'b1);
    cmp_bit("locked idle", busy, 1'b0);
    send(OP_GLOBAL_UNLOCK, 0, 24'h00_0000);
    rdlock(OP_READ_LOCK_A, 24'h12_3456, 8'h00, 1'b1);
    for (int i = 0; i < 11; i++) begin
      send(ops[i], (i > 8) ? 0 : 24, 24'h20_0000);
      cmp_bit("started", busy, 1'b1);
      send(OP_TERMINATE, 0, 24'h00_0000);
      cmp_bit("halted", f_ab, 1'b1);
      cmp_bit("no reset", f_rst, 1'b0);
    end
    send(OP_GLOBAL_LOCK, 0, 24'h00_0000);
    rdlock(OP_READ_LOCK_B, 24'h20_0000, 8'h01, 1'b1);
    send(OP_GLOBAL_UNLOCK, 0, 24'h00_0000);
    send(OP_PROG_PAGE, 24, 24'h20_0000);
    send(OP_RESET_ENABLE, 0, 24'h00_0000);
    send(OP_RESET_DEVICE, 0, 24'h00_0000);
    cmp_bit("soft reset", f_rst, 1'b1);
    cmp_bit("soft abort", busy, 1'b0);
    wait_wake;
    rdlock(OP_READ_LOCK_A, 24'h20_0000, 8'h01, 1'b1);
    send(OP_PROG_PAGE, 24, 24'h00_0000);
    send(OP_ERASE_CHIP_A, 0, 24'h00_0000);
    cmp_bit("chip erase", busy, 1'b1);
    jedec;
    cmp_bit("jedec reset", f_rst, 1'b1);
    wait_wake;
    send(OP_GLOBAL_UNLOCK, 0, 24'h00_0000);
    send(OP_PROG_PAGE, 24, 24'h20_0000);
    cmp_bit("por started", busy, 1'b1);
    resetn = 1'b0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (5) @(negedge clk);
    cmp_bit("por abort", busy, 1'b0);
    rdlock(OP_READ_LOCK_A, 24'h20_0000, 8'h01, 1'b1);
    send(OP_GLOBAL_UNLOCK, 0, 24'h00_0000);
    sel = 1'b1;
    send(OP_POWER_DOWN, 0, 24'h00_0000);
    cmp_bit("deep entered", deep, 1'b1);
    rdlock(OP_READ_LOCK_A, 24'h00_0000, 8'h00, 1'b0);
    send(OP_GLOBAL_LOCK, 0, 24'h00_0000);
    send(OP_TERMINATE, 0, 24'h00_0000);
    cmp_bit("deep held", deep, 1'b1);
    send(OP_RESUME, 0, 24'h00_0000);
    cmp_bit("deep left", deep, 1'b0);
    cmp_bit("sram kept", sram_valid, 1'b1);
    wait_wake;
    rdlock(OP_READ_LOCK_A, 24'h00_0000, 8'h00, 1'b1);
    sel = 1'b0;
    send(OP_POWER_DOWN, 0, 24'h00_0000);
    cmp_bit("deepest entered", deepest, 1'b1);
    send(OP_RESET_ENABLE, 0, 24'h00_0000);
    send(OP_RESET_DEVICE, 0, 24'h00_0000);
    cmp_bit("deepest held", deepest, 1'b1);
    send(OP_RESUME, 0, 24'h00_0000);
    cmp_bit("deepest left", deepest, 1'b0);
    cmp_bit("sram lost", sram_valid, 1'b0);
    wait_wake;
    rdlock(OP_READ_LOCK_A, 24'h00_0000, 8'h01, 1'b1);
    sel = 1'b1;
    send(OP_DEEPEST_DOWN, 0, 24'h00_0000);
    cmp_bit("deepest by 79", deepest, 1'b1);
    pin_en = 1'b1;
    reset_pin_n = 1'b0;
    repeat (10) @(negedge clk);
    reset_pin_n = 1'b1;
    repeat (8) @(negedge clk);
    cmp_bit("pin wake", deepest, 1'b0);
    wait_wake;
    send(OP_POWER_DOWN, 0, 24'h00_0000);
    send(OP_RESET_ENABLE, 0, 24'h00_0000);
    send(OP_RESET_DEVICE, 0, 24'h00_0000);
    cmp_bit("soft wake", deep, 1'b0);
    wait_wake;
    send(OP_POWER_DOWN, 0, 24'h00_0000);
    jedec;
    cmp_bit("jedec wake", deep, 1'b0);
    wait_wake;
    end_sim;
  end
endmodule : testbench
`default_nettype wire
